// File: aisc_defines.vh
// register map, field positions and reset values of the input select block
`ifndef AISC_DEFINES_VH
`define AISC_DEFINES_VH

// byte addresses on the register bus
`define AISC_ADDR_DEPTH 8'h00
`define AISC_ADDR_AUX 8'h04
`define AISC_ADDR_MAIN 8'h08
`define AISC_ADDR_SCANH 8'h0c
`define AISC_ADDR_SCANL 8'h10
`define AISC_ADDR_CTRL 8'h14
`define AISC_ADDR_STAT 8'h18

// writable bit masks of each register except the read-only status register
`define AISC_MASK_DEPTH 16'h0007
`define AISC_MASK_AUX 16'h0707
`define AISC_MASK_MAIN 16'h9f9f
`define AISC_MASK_MAIN2 16'h8f8f
`define AISC_MASK_CTRL 16'h0f0f
`define AISC_MASK_CTRL_WIDE 16'h0f03
`define AISC_MASK_SCAN 16'hffff

// reset values
`define AISC_RST16 16'h0000

// aux select fields
`define AISC_AUX_NEG_B 10:9
`define AISC_AUX_POS_B 8
`define AISC_AUX_NEG_A 2:1
`define AISC_AUX_POS_A 0

// main select fields
`define AISC_MAIN_NEG_B 15
`define AISC_MAIN_POS_B 12:8
`define AISC_MAIN_NEG_A 7
`define AISC_MAIN_POS_A 4:0

// control fields
`define AISC_CTL_ALT 0
`define AISC_CTL_SCAN 1
`define AISC_CTL_USED 3:2
`define AISC_CTL_WIDE 8

// aux input numbers
`define AISC_AUX_POS_LO 5'h00
`define AISC_AUX_POS_HI 5'h03
`define AISC_AUX_NEG_LO 5'h06
`define AISC_AUX_NEG_HI 5'h09
`define AISC_IN_AN1 5'h01

// channel enable patterns
`define AISC_CH_ONE 4'h1
`define AISC_CH_TWO 4'h3
`define AISC_CH_ALL 4'hf

`endif

// File: aisc_scan_step.v
// finds the next enabled scan input after the current one, wrapping
`timescale 1ns/100ps
module aisc_scan_step #(
  parameter N = 32,
  parameter W = 5
) (
  // mask and position
  input wire [N-1:0] mask,
  input wire [W-1:0] cur,
  // result
  output reg [W-1:0] next,
  output reg found
);
  integer i;
  integer k;

  // scan from cur+1 upward, wrapping, first set bit wins
  always @* begin
    next = cur;
    found = 1'b0;
    for (i = N; i >= 1; i = i - 1) begin
      k = (cur + i) % N;
      if (mask[k]) begin
        next = k[W-1:0];
        found = 1'b1;
      end
    end
  end
endmodule

// File: aisc_top.v
// converter input select registers with apb access and mux select outputs
`timescale 1ns/100ps
`include "aisc_defines.vh"
module aisc_top #(
  parameter NUM_INPUTS = 32,
  parameter SECOND_CONVERTER = 0
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // converter sequencer
  input wire sample_done,
  // mux selects for channel 0
  output reg [4:0] main_pos_input,
  output reg main_pos_to_ref,
  output reg main_neg_an1,
  // mux selects for channels 1 to 3
  output reg [4:0] aux_pos_base,
  output reg [4:0] aux_neg_base,
  output reg aux_neg_to_ref,
  // sequencing and dma
  output reg [3:0] channel_enable,
  output reg [7:0] buffer_words,
  output reg sample_set_b
);
  // register state
  reg [15:0] depth_reg;
  reg [15:0] aux_reg;
  reg [15:0] main_reg;
  reg [15:0] scanh_reg;
  reg [15:0] scanl_reg;
  reg [15:0] ctrl_reg;
  reg set_b_reg;
  reg [4:0] scan_ptr_reg;
  reg [4:0] scan_ptr_next;
  reg set_b_next;

  // decoded bus strobes, control bits and scan mask
  wire access = psel & penable & ~pready;
  wire wr_en = psel & penable & pready & pwrite;
  wire [15:0] wdata = pwdata[15:0];
  wire wide_mode = ctrl_reg[`AISC_CTL_WIDE];
  wire alt_on = ctrl_reg[`AISC_CTL_ALT];
  wire scan_on = ctrl_reg[`AISC_CTL_SCAN];
  wire [31:0] scan_mask = {scanh_reg, scanl_reg};

  // masks that track mode and converter instance
  wire [15:0] main_mask = (SECOND_CONVERTER != 0) ? `AISC_MASK_MAIN2 : `AISC_MASK_MAIN;
  wire [15:0] ctrl_rd_mask = wide_mode ? `AISC_MASK_CTRL_WIDE : `AISC_MASK_CTRL;
  wire [15:0] aux_rd = wide_mode ? `AISC_RST16 : aux_reg;

  // next scan input search
  wire [4:0] step_next;
  wire step_found;
  wire [4:0] first_next;
  wire first_found;

  aisc_scan_step #(
    .N(32),
    .W(5)
  ) u_step (
    .mask(scan_mask),
    .cur(scan_ptr_reg),
    .next(step_next),
    .found(step_found)
  );

  // search from the top so the lowest enabled input comes first
  aisc_scan_step #(
    .N(32),
    .W(5)
  ) u_first (
    .mask(scan_mask),
    .cur(5'h1f),
    .next(first_next),
    .found(first_found)
  );

  // register writes, unimplemented bits dropped
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      depth_reg <= `AISC_RST16;
      aux_reg <= `AISC_RST16;
      main_reg <= `AISC_RST16;
      scanh_reg <= `AISC_RST16;
      scanl_reg <= `AISC_RST16;
      ctrl_reg <= `AISC_RST16;
    end else if (wr_en) begin
      if (paddr == `AISC_ADDR_DEPTH) begin
        depth_reg <= wdata & `AISC_MASK_DEPTH;
      end else if (paddr == `AISC_ADDR_AUX) begin
        if (!wide_mode) begin
          aux_reg <= wdata & `AISC_MASK_AUX;
        end
      end else if (paddr == `AISC_ADDR_MAIN) begin
        main_reg <= wdata & main_mask;
      end else if (paddr == `AISC_ADDR_SCANH) begin
        scanh_reg <= wdata & `AISC_MASK_SCAN;
      end else if (paddr == `AISC_ADDR_SCANL) begin
        scanl_reg <= wdata & `AISC_MASK_SCAN;
      end else if (paddr == `AISC_ADDR_CTRL) begin
        if (wdata[`AISC_CTL_WIDE]) begin
          ctrl_reg <= wdata & `AISC_MASK_CTRL_WIDE;
        end else begin
          ctrl_reg <= wdata & `AISC_MASK_CTRL;
        end
      end
    end
  end

  // apb answer: one wait cycle, then data and ready from flops
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (access) begin
        if (paddr == `AISC_ADDR_DEPTH) begin
          prdata <= {16'h0000, depth_reg};
        end else if (paddr == `AISC_ADDR_AUX) begin
          prdata <= {16'h0000, aux_rd};
        end else if (paddr == `AISC_ADDR_MAIN) begin
          prdata <= {16'h0000, main_reg};
        end else if (paddr == `AISC_ADDR_SCANH) begin
          prdata <= {16'h0000, scanh_reg};
        end else if (paddr == `AISC_ADDR_SCANL) begin
          prdata <= {16'h0000, scanl_reg};
        end else if (paddr == `AISC_ADDR_CTRL) begin
          prdata <= {16'h0000, ctrl_reg & ctrl_rd_mask};
        end else if (paddr == `AISC_ADDR_STAT) begin
          prdata <= {16'h0000, 2'h0, scan_ptr_reg, set_b_reg, 8'h00};
        end else begin
          pslverr <= 1'b1; // unmapped address
        end
      end
    end
  end

  // sample set and scan position for the next sample
  always @* begin
    set_b_next = set_b_reg;
    scan_ptr_next = scan_ptr_reg;
    if (!alt_on) begin
      set_b_next = 1'b0;
    end else if (sample_done) begin
      set_b_next = ~set_b_reg;
    end
    if (!scan_on) begin
      scan_ptr_next = first_found ? first_next : 5'h00;
    end else if (sample_done && !set_b_reg && step_found) begin
      scan_ptr_next = step_next;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      set_b_reg <= 1'b0;
      scan_ptr_reg <= 5'h00;
    end else begin
      set_b_reg <= set_b_next;
      scan_ptr_reg <= scan_ptr_next;
    end
  end

  // selected set fields
  reg [4:0] pos_sel;
  reg neg_sel;
  reg aux_pos_sel;
  reg [1:0] aux_neg_sel;

  always @* begin
    if (set_b_next) begin
      pos_sel = main_reg[`AISC_MAIN_POS_B];
      neg_sel = main_reg[`AISC_MAIN_NEG_B];
      aux_pos_sel = aux_reg[`AISC_AUX_POS_B];
      aux_neg_sel = aux_reg[`AISC_AUX_NEG_B];
    end else begin
      pos_sel = scan_on ? scan_ptr_next : main_reg[`AISC_MAIN_POS_A];
      neg_sel = main_reg[`AISC_MAIN_NEG_A];
      aux_pos_sel = aux_reg[`AISC_AUX_POS_A];
      aux_neg_sel = aux_reg[`AISC_AUX_NEG_A];
    end
    if (SECOND_CONVERTER != 0) begin
      pos_sel[4] = 1'b0;
    end
    if (wide_mode) begin
      aux_pos_sel = 1'b0;
      aux_neg_sel = 2'b00;
    end
  end

  // registered mux selects, stable between events
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      main_pos_input <= 5'h00;
      main_pos_to_ref <= 1'b0;
      main_neg_an1 <= 1'b0;
      aux_pos_base <= `AISC_AUX_POS_LO;
      aux_neg_base <= `AISC_AUX_POS_LO;
      aux_neg_to_ref <= 1'b1;
      channel_enable <= `AISC_CH_ONE;
      buffer_words <= 8'h01;
      sample_set_b <= 1'b0;
    end else begin
      main_pos_input <= pos_sel;
      main_pos_to_ref <= ({27'h0, pos_sel} >= NUM_INPUTS);
      main_neg_an1 <= neg_sel;
      aux_pos_base <= aux_pos_sel ? `AISC_AUX_POS_HI : `AISC_AUX_POS_LO;
      if (aux_neg_sel == 2'b11) begin
        aux_neg_base <= `AISC_AUX_NEG_HI;
        aux_neg_to_ref <= 1'b0;
      end else if (aux_neg_sel == 2'b10) begin
        aux_neg_base <= `AISC_AUX_NEG_LO;
        aux_neg_to_ref <= 1'b0;
      end else begin
        aux_neg_base <= `AISC_AUX_POS_LO;
        aux_neg_to_ref <= 1'b1;
      end
      if (wide_mode || ctrl_reg[`AISC_CTL_USED] == 2'b00) begin
        channel_enable <= `AISC_CH_ONE;
      end else if (ctrl_reg[`AISC_CTL_USED] == 2'b01) begin
        channel_enable <= `AISC_CH_TWO;
      end else begin
        channel_enable <= `AISC_CH_ALL;
      end
      buffer_words <= 8'h01 << depth_reg[2:0];
      sample_set_b <= set_b_next;
    end
  end
endmodule

// File: aisc_seq_model.sv
// converter sequencer model: one sample_done per start request
`timescale 1ns/100ps
module aisc_seq_model (
  // clock and reset
  input wire clk,
  input wire reset,
  // sample request and completion
  input wire start,
  output reg sample_done,
  output wire busy
);
  reg [2:0] wait_reg;
  // a started sample finishes after a few conversion cycles
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_reg <= 3'h0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= wait_reg == 3'h1;
      if (start)
        wait_reg <= 3'h5;
      else if (wait_reg != 3'h0)
        wait_reg <= wait_reg - 3'h1;
    end
  end
  assign busy = start || wait_reg != 3'h0;
endmodule

// File: aisc_top_sva.sv
// assertions on the input select block ports
`timescale 1ns/100ps
module aisc_top_sva #(
  parameter NUM_INPUTS = 32,
  parameter SECOND_CONVERTER = 0
) (
  // clock, reset and bus
  input logic clk,
  input logic reset,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  // sequencer and mux selects
  input logic sample_done,
  input logic [4:0] main_pos_input,
  input logic main_pos_to_ref,
  input logic main_neg_an1,
  input logic [4:0] aux_pos_base,
  input logic [4:0] aux_neg_base,
  input logic aux_neg_to_ref,
  input logic [3:0] channel_enable,
  input logic [7:0] buffer_words,
  input logic sample_set_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [15:0] d_reg, a_reg, m_reg, c_reg;
  logic [2:0] s;
  // shadow copies of accepted writes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      d_reg <= 16'h0000;
      a_reg <= 16'h0000;
      m_reg <= 16'h0000;
      c_reg <= 16'h0000;
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      case (paddr)
        8'h00: d_reg <= pwdata[15:0];
        8'h04: a_reg <= c_reg[8] ? a_reg : pwdata[15:0];
        8'h08: m_reg <= pwdata[15:0] & ((SECOND_CONVERTER != 0) ? 16'h8f8f : 16'h9f9f);
        8'h14: c_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  assign s = sample_set_b ? a_reg[10:8] : a_reg[2:0];
  // no bus traffic and no finished sample for three cycles
  sequence settled;
    (!psel && !sample_done)[*3];
  endsequence
  a_depth_words: assert property (settled |-> buffer_words == 8'h01 << d_reg[2:0])
    else $error("buffer words wrong");
  a_chan_count: assert property (settled |-> channel_enable ==
    (c_reg[8] ? 4'h1 : c_reg[3] ? 4'hf : c_reg[2] ? 4'h3 : 4'h1)) else $error("enables wrong");
  a_main_neg: assert property (settled |-> main_neg_an1 == (sample_set_b ? m_reg[15] : m_reg[7]))
    else $error("ch0 negative wrong");
  a_main_pos: assert property (settled ##0 (sample_set_b || !c_reg[1]) |->
    main_pos_input == (sample_set_b ? m_reg[12:8] : m_reg[4:0])) else $error("ch0 positive wrong");
  a_aux_pos: assert property (settled ##0 !c_reg[8] |-> aux_pos_base == (s[0] ? 5'h03 : 5'h00))
    else $error("aux positive wrong");
  a_aux_neg: assert property (settled ##0 !c_reg[8] |-> aux_neg_to_ref == !s[2] &&
    aux_neg_base == (s[2] ? (s[1] ? 5'h09 : 5'h06) : 5'h00)) else $error("aux negative wrong");
  a_ref_input: assert property (settled |-> main_pos_to_ref == (main_pos_input >= NUM_INPUTS))
    else $error("missing input not at reference");
  a_alt_toggle: assert property (sample_done && c_reg[0] |-> ##[1:2] $changed(sample_set_b))
    else $error("sample set did not alternate");
  a_mux_hold: assert property (settled |=> $stable(main_pos_input) && $stable(aux_neg_base) &&
    $stable(main_neg_an1)) else $error("mux select moved while idle");
endmodule
bind aisc_top aisc_top_sva #(.NUM_INPUTS(NUM_INPUTS), .SECOND_CONVERTER(SECOND_CONVERTER))
  sva_u (.clk, .reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .sample_done, .main_pos_input, .main_pos_to_ref,
  .main_neg_an1, .aux_pos_base, .aux_neg_base, .aux_neg_to_ref, .channel_enable,
  .buffer_words, .sample_set_b);

// File: aisc_top_tb.sv
// self-checking bench for the input select registers
`timescale 1ns/100ps
module aisc_top_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sample_done, busy, main_pos_to_ref, main_neg_an1;
  logic aux_neg_to_ref, sample_set_b;
  logic [4:0] main_pos_input, aux_pos_base, aux_neg_base, main_pos2;
  logic [3:0] channel_enable;
  logic [7:0] buffer_words;
  logic [31:0] wmask [5] = '{32'h7, 32'h707, 32'h9f9f, 32'hffff, 32'hffff};
  int mismatches = 0, comparisons = 0, i;
  always #25 clk = ~clk;
  aisc_top #(.NUM_INPUTS(24)) dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sample_done, .main_pos_input, .main_pos_to_ref, .main_neg_an1,
    .aux_pos_base, .aux_neg_base, .aux_neg_to_ref, .channel_enable, .buffer_words, .sample_set_b);
  aisc_seq_model seq_u (.clk, .reset, .start, .sample_done, .busy);
  // second converter instance on the same bus, only its channel 0 positive select is watched
  aisc_top #(.SECOND_CONVERTER(1)) dut2_u (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata(), .pready(), .pslverr(), .sample_done, .main_pos_input(main_pos2),
    .main_pos_to_ref(), .main_neg_an1(), .aux_pos_base(), .aux_neg_base(), .aux_neg_to_ref(),
    .channel_enable(), .buffer_words(), .sample_set_b());
  task summarize;
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, then three idle cycles
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      summarize;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  // one finished sample from the sequencer model
  task samp;
    int n;
    n = 0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (busy === 1'b1) begin
      mismatches++;
      summarize;
    end
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 7; i++)
      rdc("reset value", 8'(i * 4), 32'h0);
    chk("buffer words", 32'h1, {24'h0, buffer_words});
    for (i = 0; i < 5; i++) begin
      xfer(1'b1, 8'(i * 4), 32'hffffffff);
      rdc("writable bits", 8'(i * 4), wmask[i]);
    end
    chk("ref input", 32'h1, {31'h0, main_pos_to_ref});
    chk("second converter", 32'hf, {27'h0, main_pos2});
    for (i = 0; i < 8; i++) begin
      xfer(1'b1, 8'h00, 32'(i));
      chk("buffer words", 32'h1 << i, {24'h0, buffer_words});
      xfer(1'b1, 8'h04, 32'(i));
      chk("aux positive", i[0] ? 32'h3 : 32'h0, {27'h0, aux_pos_base});
      chk("aux negative", i[2] ? (i[1] ? 32'h9 : 32'h6) : 32'h0, {27'h0, aux_neg_base});
      chk("aux reference", i[2] ? 32'h0 : 32'h1, {31'h0, aux_neg_to_ref});
    end
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h14, 32'(i * 4));
      chk("channels", i == 0 ? 32'h1 : i == 1 ? 32'h3 : 32'hf, {28'h0, channel_enable});
    end
    xfer(1'b1, 8'h08, 32'h9103);
    xfer(1'b1, 8'h04, 32'h0601);
    xfer(1'b1, 8'h14, 32'h1);
    for (i = 0; i < 2; i++) begin
      chk("set select", i[0] ? 32'h1c409 : 32'h00c60, {15'h0, sample_set_b, main_neg_an1,
        main_pos_input, aux_pos_base, aux_neg_base});
      chk("second converter", i[0] ? 32'h1 : 32'h3, {27'h0, main_pos2});
      samp;
    end
    xfer(1'b1, 8'h10, 32'h4);
    xfer(1'b1, 8'h0c, 32'h1);
    xfer(1'b1, 8'h14, 32'h2);
    for (i = 0; i < 3; i++) begin
      chk("scan input", i[0] ? 32'h10 : 32'h2, {27'h0, main_pos_input});
      samp;
    end
    xfer(1'b1, 8'h1c, 32'hffff);
    chk("error flag", 32'h1, {31'h0, err});
    rdc("unmapped", 8'h1c, 32'h0);
    xfer(1'b1, 8'h14, 32'h10c);
    rdc("control", 8'h14, 32'h100);
    xfer(1'b1, 8'h04, 32'h707);
    rdc("aux in wide mode", 8'h04, 32'h0);
    chk("channels", 32'h1, {28'h0, channel_enable});
    summarize;
  end
endmodule
